// ===== rtl/sigma_delta_result_formatter.sv
// Output-side logic of a 24-bit delta-sigma converter: sequencing,
// gain and offset scaling, saturation, end-of-conversion flagging.
// Assumes the decimation filter delivers one ratio code per valid pulse
// on ref_clk_i, already scaled by 2^23 at unity gain.
`timescale 1ns/100ps
`default_nettype none

module sigma_delta_result_formatter
	import sdrf_pkg::*;
#(
	parameter int RAW_W  = 24,                           // Filter code width
	parameter int WIDE_W = 40                            // Internal math width
) (
	// Clock and reset
	input  wire logic                ref_clk_i,
	input  wire logic                rst_i,
	// Software control bits
	input  wire logic                conv_power_off_i,
	input  wire logic                conv_restart_bit_i,
	input  wire logic                reference_select_i,
	input  wire gain_cfg_type        gain_cfg_i,
	input  wire logic [RESULT_W-1:0] input_offset_setting_i,
	input  wire logic [CHAN_W-1:0]   pos_chan_sel_i,
	input  wire logic [CHAN_W-1:0]   neg_chan_sel_i,
	input  wire logic                eoc_clear_i,
	input  wire logic                irq_clear_i,
	// Filter side
	input  wire logic                sample_valid_i,
	input  wire logic [RAW_W-1:0]    sample_i,
	// Analog control
	output logic                     analog_enable_o,
	output logic                     filter_reset_o,
	output logic                     reference_select_o,
	output logic                     temp_sensor_enable_o,
	// Status and result
	output logic                     end_of_conversion_o,
	output logic                     conv_irq_o,
	output logic [BYTE_W-1:0]        result_low_byte_o,
	output logic [BYTE_W-1:0]        result_mid_byte_o,
	output logic [BYTE_W-1:0]        result_high_byte_o
);

	// Shifted sample must fit with the largest gain exponent
	if (RAW_W < 2 || RAW_W > RESULT_W || WIDE_W < RAW_W + 11) begin : g_chk
		$error("sigma_delta_result_formatter: bad RAW_W or WIDE_W");
	end

	conv_state_type      state_r;                        // Sequencer state
	conv_state_type      state_nxt;                      // Next state
	logic [RESULT_W-1:0] result_r;                       // Latest result code
	logic [RESULT_W-1:0] sat_code;                       // Clamped code
	logic [WIDE_W-1:0]   wide_val;                       // Scaled value
	logic [SHIFT_W-1:0]  up_shift;                       // Amp plus conv gain
	logic                accept;                         // Sample taken
	logic                eoc_r;                          // End of conversion
	logic                irq_r;                          // Interrupt request
	logic                analog_en_r;                    // Circuitry powered
	logic                filt_rst_r;                     // Filter held reset
	logic                ref_sel_r;                      // Reference choice
	logic                temp_en_r;                      // Sensor routed

	// Sequencer next state; power-off overrides everything
	always_comb begin
		state_nxt = state_r;
		if (conv_power_off_i) begin
			state_nxt = ST_OFF;
		end else begin
			unique case (state_r)
				ST_OFF: begin
					state_nxt = ST_IDLE;
				end
				ST_IDLE: begin
					if (conv_restart_bit_i) begin        // Restart bit high
						state_nxt = ST_RESTART;
					end
				end
				ST_RESTART: begin
					if (!conv_restart_bit_i) begin       // Falling edge
						state_nxt = ST_RUN;
					end
				end
				ST_RUN: begin
					if (conv_restart_bit_i) begin        // Restart anew
						state_nxt = ST_RESTART;
					end
				end
			endcase
		end
	end

	// Sequencer register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= ST_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Only a running, powered converter produces results
	assign accept = sample_valid_i && (state_r == ST_RUN) && !conv_power_off_i;

	// Gains are powers of two: amp and converter raise, reference divides
	assign up_shift = SHIFT_W'(gain_cfg_i.amp_gain_field)
		+ SHIFT_W'(gain_cfg_i.conv_gain_field);

	// Sign-extend, amplify, add offset, then divide by the reference gain
	always_comb begin
		wide_val = WIDE_W'($signed(sample_i)) << up_shift;
		wide_val = wide_val + WIDE_W'($signed(input_offset_setting_i));
		wide_val = WIDE_W'($signed(wide_val)
			>>> gain_cfg_i.ref_gain_field);
	end

	result_saturator #(
		.IN_W    (WIDE_W)
	) u_sat (
		.value_i (wide_val),
		.code_o  (sat_code)
	);

	// Result register keeps the last code until the next conversion
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_r <= RESULT_RST;
		end else if (accept) begin
			result_r <= sat_code;
		end
	end

	// Flags: a new conversion wins over a clear in the same cycle
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			eoc_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			if (accept) begin
				eoc_r <= 1'b1;
			end else if (eoc_clear_i) begin
				eoc_r <= 1'b0;
			end
			if (accept) begin
				irq_r <= 1'b1;
			end else if (irq_clear_i) begin
				irq_r <= 1'b0;
			end
		end
	end

	// Analog controls, registered so outputs come from flip-flops
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			analog_en_r <= 1'b0;
			filt_rst_r  <= 1'b1;
			ref_sel_r   <= 1'b0;
			temp_en_r   <= 1'b0;
		end else begin
			analog_en_r <= !conv_power_off_i;
			filt_rst_r  <= (state_nxt != ST_RUN);
			ref_sel_r   <= reference_select_i;
			// Sensor is off with power-off to draw nothing
			temp_en_r   <= !conv_power_off_i
				&& ((pos_chan_sel_i == TEMP_POS_CHAN)
				|| (neg_chan_sel_i == TEMP_NEG_CHAN));
		end
	end

	// Result bytes straight from the result register
	assign result_low_byte_o    = result_r[BYTE_W-1:0];
	assign result_mid_byte_o    = result_r[2*BYTE_W-1:BYTE_W];
	assign result_high_byte_o   = result_r[3*BYTE_W-1:2*BYTE_W];
	assign end_of_conversion_o  = eoc_r;
	assign conv_irq_o           = irq_r;
	assign analog_enable_o      = analog_en_r;
	assign filter_reset_o       = filt_rst_r;
	assign reference_select_o   = ref_sel_r;
	assign temp_sensor_enable_o = temp_en_r;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// Power-off drops the analog enable on the next edge
	AST_POWER_OFF: assert property (
		conv_power_off_i |=> !analog_enable_o && !temp_sensor_enable_o)
		else $error("power-off did not disable circuitry");

	// No result update while powered off
	AST_OFF_FROZEN: assert property (
		conv_power_off_i |=> $stable(result_r) && state_r == ST_OFF)
		else $error("result changed while powered off");

	// Sign bit of the code follows the sign of the scaled value
	AST_SIGN: assert property (
		accept |=> result_r[RESULT_W-1] == $past(wide_val[WIDE_W-1]))
		else $error("result sign does not match input sign");

	// Above positive full scale clamps to the maximum code
	AST_CLAMP_POS: assert property (
		accept && !wide_val[WIDE_W-1] && (|wide_val[WIDE_W-1:SCALE_SHIFT])
		|=> result_r == FULL_POS)
		else $error("positive overrange not clamped");

	// Below negative full scale clamps to the minimum code
	AST_CLAMP_NEG: assert property (
		accept && wide_val[WIDE_W-1] && !(&wide_val[WIDE_W-1:SCALE_SHIFT])
		|=> result_r == FULL_NEG)
		else $error("negative overrange not clamped");

	// In-range values pass unchanged into the result
	AST_SCALE: assert property (
		accept && ((&wide_val[WIDE_W-1:SCALE_SHIFT])
		|| !(|wide_val[WIDE_W-1:SCALE_SHIFT]))
		|=> result_r == $past(wide_val[RESULT_W-1:0]))
		else $error("in-range result altered");

	// Restart high then low reaches the running state; the filter reset
	// is registered from the next state, so it drops on that same edge
	AST_RESTART: assert property (
		state_r == ST_IDLE && conv_restart_bit_i && !conv_power_off_i
		##1 !conv_restart_bit_i && !conv_power_off_i
		|=> state_r == ST_RUN && !filter_reset_o)
		else $error("restart sequence did not start conversion");

	// Each conversion raises both flags and the bytes carry the code
	AST_EOC: assert property (
		accept |=> end_of_conversion_o && conv_irq_o
		&& {result_high_byte_o, result_mid_byte_o, result_low_byte_o}
		== $past(sat_code))
		else $error("conversion end not flagged or bytes wrong");

	// Flag stays set until cleared
	AST_EOC_HOLD: assert property (
		end_of_conversion_o && !eoc_clear_i |=> end_of_conversion_o)
		else $error("end-of-conversion flag lost");

	// Positive temperature channel selection enables the sensor
	AST_TEMP: assert property (
		!conv_power_off_i && pos_chan_sel_i == TEMP_POS_CHAN
		|=> temp_sensor_enable_o)
		else $error("temperature sensor not enabled");

	// Reference choice reaches the analog side one edge later
	AST_REF: assert property (
		$changed(reference_select_i) |=> $changed(reference_select_o))
		else $error("reference select not forwarded");

endmodule // sigma_delta_result_formatter

`default_nettype wire

// ===== rtl/sdrf_pkg.sv
// Constants, types and state codes for the delta-sigma result formatter.
// Assumes one clock domain; every control bit arrives as a plain port.
//
// Behaviour
// - Power-off bit shuts all converter circuitry down
// - Results are 24-bit two's complement codes
// - Result MSB is sign, one means negative
// - Codes span 8388607 down to -8388608
// - Out-of-range inputs saturate, never wrap
// - Result equals amplified input over reference times 2^23
// - Three gain fields set amp, converter, reference gains
// - Reference-select bit picks the full-scale reference
// - Temperature sensor channels route into the result
// - Restart bit high then low starts conversion
// - End of conversion sets flag and interrupt request
// - Result presented as low, mid, high bytes

package sdrf_pkg;

	// Result format
	localparam int          RESULT_W    = 24;            // Result code width
	localparam int          BYTE_W      = 8;             // Result byte register width
	localparam int          NUM_BYTES   = 3;             // Result byte registers
	localparam int          SCALE_SHIFT = 23;            // K = 2^23
	localparam logic [23:0] FULL_POS    = 24'h7FFFFF;    // +8388607
	localparam logic [23:0] FULL_NEG    = 24'h800000;    // -8388608
	localparam logic [23:0] RESULT_RST  = 24'h000000;    // Middle code

	// Gain field widths
	localparam int AMP_GAIN_W  = 3;                      // Amplifier gain field
	localparam int CONV_GAIN_W = 2;                      // Converter gain field
	localparam int REF_GAIN_W  = 2;                      // Reference gain field
	localparam int SHIFT_W     = 4;                      // Sum of amp and converter gain exponents

	// Channel selection codes of the temperature sensor outputs
	localparam int         CHAN_W        = 4;            // Channel select width
	localparam logic [3:0] TEMP_POS_CHAN = 4'hF;         // Sensor positive out
	localparam logic [3:0] TEMP_NEG_CHAN = 4'hF;         // Sensor negative out

	// Gain configuration, each field an exponent of two
	typedef struct packed {
		logic [AMP_GAIN_W-1:0]  amp_gain_field;          // Amplifier gain
		logic [CONV_GAIN_W-1:0] conv_gain_field;         // Converter gain
		logic [REF_GAIN_W-1:0]  ref_gain_field;          // Reference gain
	} gain_cfg_type;

	// Converter sequencing states
	typedef enum logic [1:0] {
		ST_OFF     = 2'b00,                              // Powered down
		ST_IDLE    = 2'b01,                              // Awaiting restart
		ST_RESTART = 2'b10,                              // Restart bit held high
		ST_RUN     = 2'b11                               // Converting
	} conv_state_type;

endpackage

// ===== rtl/result_saturator.sv
// Clamp of a wide signed value onto the 24-bit result code range.
// Pure combinational; the caller registers the output.
`timescale 1ns/100ps
`default_nettype none

module result_saturator
	import sdrf_pkg::*;
#(
	parameter int IN_W = 40                              // Width of wide value
) (
	// Wide signed value
	input  wire logic [IN_W-1:0]     value_i,
	// Clamped code
	output logic      [RESULT_W-1:0] code_o
);

	// The wide value needs headroom above the result width
	if (IN_W <= RESULT_W) begin : g_chk
		$error("result_saturator: IN_W must exceed RESULT_W");
	end

	// Bits above the result sign must all match the sign to fit
	logic [IN_W-RESULT_W:0] upper;                       // Sign and headroom

	assign upper = value_i[IN_W-1:RESULT_W-1];

	// Saturate instead of wrapping so a large input never flips sign
	always_comb begin
		if (&upper || ~|upper) begin                     // In range
			code_o = value_i[RESULT_W-1:0];
		end else if (value_i[IN_W-1]) begin
			code_o = FULL_NEG;
		end else begin                                   // Above positive FS
			code_o = FULL_POS;
		end
	end

endmodule // result_saturator

`default_nettype wire

// ===== bench/sigma_delta_result_formatter_tb_top.sv
// Self-checking bench for the delta-sigma result formatter.
// Assumes sdrf_pkg and the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module sigma_delta_result_formatter_tb_top;
	import sdrf_pkg::*;

	// Stimulus, all driven at the falling edge
	logic         ref_clk_i = 1'b0;
	logic         rst_i     = 1'b1;
	logic         pwr_off   = 1'b1;
	logic         restart   = 1'b0;
	logic         ref_sel   = 1'b0;
	gain_cfg_type gain_cfg  = '0;
	logic [23:0]  offset    = 24'h000000;
	logic [3:0]   pos_sel   = 4'h0;
	logic [3:0]   neg_sel   = 4'h0;
	logic         eoc_clr   = 1'b0;
	logic         irq_clr   = 1'b0;
	logic         valid     = 1'b0;
	logic [23:0]  sample    = 24'h000000;
	// Observed outputs
	logic         ana_en, flt_rst, ref_q, temp_en, eoc, irq;
	logic [7:0]   lo, mid, hi;
	// Bookkeeping
	logic [23:0]  exp_q[$];              // Expected codes, oldest first
	int           bad_count       = 0;
	int           samples_checked = 0;
	int           seed            = 15;
	logic         eoc_prev        = 1'b0;

	// 5 ns period
	always #2.5 ref_clk_i = ~ref_clk_i;

	sigma_delta_result_formatter sigma_delta_result_formatter_inst (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.conv_power_off_i(pwr_off), .conv_restart_bit_i(restart),
		.reference_select_i(ref_sel), .gain_cfg_i(gain_cfg),
		.input_offset_setting_i(offset), .pos_chan_sel_i(pos_sel),
		.neg_chan_sel_i(neg_sel), .eoc_clear_i(eoc_clr),
		.irq_clear_i(irq_clr), .sample_valid_i(valid), .sample_i(sample),
		.analog_enable_o(ana_en), .filter_reset_o(flt_rst),
		.reference_select_o(ref_q), .temp_sensor_enable_o(temp_en),
		.end_of_conversion_o(eoc), .conv_irq_o(irq),
		.result_low_byte_o(lo), .result_mid_byte_o(mid),
		.result_high_byte_o(hi));

	// Single-bit comparison
	task automatic check_bit(input string nm, input logic e, input logic s);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %b seen %b", nm, e, s);
		end
	endtask

	// Result code comparison
	task automatic check_code(input logic [23:0] e, input logic [23:0] s);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value result expected %h seen %h", e, s);
		end
	endtask

	// Reference model: shift by gains, add offset, divide, clamp
	function automatic logic [23:0] model(input logic [23:0] s);
		longint v;
		v = longint'(signed'(s)) <<< (int'(gain_cfg.amp_gain_field)
			+ int'(gain_cfg.conv_gain_field));
		v = v + longint'(signed'(offset));
		v = v >>> gain_cfg.ref_gain_field;
		if (v > 64'sd8388607)
			v = 64'sd8388607;
		else if (v < -64'sd8388608)
			v = -64'sd8388608;
		return v[23:0];
	endfunction

	// One sample, then clear both flags; acc says whether it counts
	task automatic send(input logic [23:0] s, input bit acc);
		@(negedge ref_clk_i);
		valid = 1'b1;
		sample = s;
		if (acc)
			exp_q.push_back(model(s));
		@(negedge ref_clk_i);
		valid = 1'b0;
		eoc_clr = 1'b1;
		irq_clr = 1'b1;
		@(negedge ref_clk_i);
		eoc_clr = 1'b0;
		irq_clr = 1'b0;
		check_bit("eoc after clear", 1'b0, eoc);
		check_bit("irq after clear", 1'b0, irq);
	endtask

	// Power up and pulse the restart bit high then low
	task automatic start_conv;
		@(negedge ref_clk_i);
		pwr_off = 1'b0;
		@(negedge ref_clk_i);
		restart = 1'b1;
		@(negedge ref_clk_i);
		restart = 1'b0;
		check_bit("filter_reset held", 1'b1, flt_rst);
		@(negedge ref_clk_i);
		check_bit("filter_reset", 1'b0, flt_rst);
		check_bit("analog_enable", 1'b1, ana_en);
	endtask

	// Watcher: a rising end flag consumes the oldest expected code
	always @(posedge ref_clk_i) begin
		#1;
		if (eoc === 1'b1 && eoc_prev !== 1'b1) begin
			if (exp_q.size() == 0) begin
				bad_count++;
				$display("wrong value eoc expected 0 seen 1");
			end else begin
				check_code(exp_q.pop_front(), {hi, mid, lo});
				check_bit("irq", 1'b1, irq);
			end
		end
		eoc_prev = eoc;
	end

	// Closing report and verdict
	task automatic stop_test;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Hang guard: a run this long counts as a mismatch
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		bad_count++;
		$display("wrong value run length expected done seen timeout");
		stop_test();
	end

	// Main sequence
	initial begin
		logic [23:0] edge_s[6];
		logic [23:0] edge_o[6];
		edge_s = '{24'h7FFFFF, 24'h800000, 24'h000000, 24'hFFFFFF,
			24'h7FFFFF, 24'h800000};
		edge_o = '{24'h000000, 24'h000000, 24'h000000, 24'h000000,
			24'h000001, 24'hFFFFFF};
		repeat (4) @(negedge ref_clk_i);
		check_code(24'h000000, {hi, mid, lo});
		check_bit("analog_enable reset", 1'b0, ana_en);
		rst_i = 1'b0;
		// Samples while off are dropped and circuitry stays off
		send(24'h123456, 0);
		check_bit("analog_enable off", 1'b0, ana_en);
		$display("test power_off done");
		start_conv();
		// Reference and temperature routing
		ref_sel = 1'b1;
		pos_sel = TEMP_POS_CHAN;
		@(negedge ref_clk_i);
		check_bit("reference_select", 1'b1, ref_q);
		check_bit("temp_enable pos", 1'b1, temp_en);
		pos_sel = 4'h0;
		neg_sel = TEMP_NEG_CHAN;
		@(negedge ref_clk_i);
		check_bit("temp_enable neg", 1'b1, temp_en);
		neg_sel = 4'h0;
		ref_sel = 1'b0;
		@(negedge ref_clk_i);
		check_bit("temp_enable none", 1'b0, temp_en);
		check_bit("reference_select low", 1'b0, ref_q);
		$display("test routing done");
		// Every gain combination with random codes
		for (int g = 0; g < 128; g++) begin
			gain_cfg = gain_cfg_type'(g[6:0]);
			offset = 24'($random(seed)) >>> 4;
			send(24'($random(seed)), 1);
		end
		gain_cfg = '0;
		$display("test gains done");
		// Full-scale codes and saturation by offset
		for (int i = 0; i < 6; i++) begin
			offset = edge_o[i];
			send(edge_s[i], 1);
		end
		offset = 24'h000000;
		$display("test full_scale done");
		// Restart high in mid-run stops acceptance until released
		@(negedge ref_clk_i);
		restart = 1'b1;
		send(24'h000100, 0);
		restart = 1'b0;
		@(negedge ref_clk_i);
		send(24'h000200, 1);
		// Power off mid-run, then a fresh start
		pwr_off = 1'b1;
		pos_sel = TEMP_POS_CHAN;
		send(24'h000300, 0);
		check_bit("analog_enable drop", 1'b0, ana_en);
		check_bit("temp_enable off", 1'b0, temp_en);
		pos_sel = 4'h0;
		// Reset while powered off clears the result and the flags
		rst_i = 1'b1;
		@(negedge ref_clk_i);
		check_code(RESULT_RST, {hi, mid, lo});
		check_bit("eoc reset", 1'b0, eoc);
		rst_i = 1'b0;
		start_conv();
		send(24'h400000, 1);
		$display("test restart done");
		check_bit("queue empty", 1'b1, exp_q.size() == 0);
		stop_test();
	end

endmodule // sigma_delta_result_formatter_tb_top

`default_nettype wire
